// *** rfid_link_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module rfid_link_assertions (
    input wire logic clk,       // clock
    input wire logic rst,       // reset
    input wire logic field_on,  // field
    input wire logic wr_valid,  // write strobe
    input wire logic wr_bit,    // write bit
    input wire logic wr_end,    // write over
    input wire logic rd_valid,  // reply strobe
    input wire logic rd_bit,    // reply bit
    input wire logic rd_last    // final bit
);
    logic [7:0] pos;  // reply bit index
    // places every reply bit inside the frame
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pos <= 8'h00;
        end else begin
            pos <= rd_valid ? pos + 8'h01 : 8'h00;
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_reply_after_end: assert property ($rose(rd_valid) |-> $past(wr_end, 3))
        else $error("reply start not three cycles after write end");
    a_frame_length: assert property (rd_last |-> rd_valid && pos == 8'h7f)
        else $error("reply frame length wrong");
    a_pre_bits_zero: assert property (rd_valid && pos < 8'h10 |-> !rd_bit)
        else $error("pre bit not zero");
    a_start_byte: assert property (rd_valid && pos >= 8'h10 && pos < 8'h18
        |-> rd_bit == rfid_page_pkg::START_BYTE[3'(pos - 8'h10)])
        else $error("start byte wrong");
    a_silent_after_last: assert property (rd_last |=> !rd_valid)
        else $error("reply ran past last bit");
    // two ones in the status field would be the reserved code
    a_no_reserved: assert property (rd_valid && pos == 8'h69 |-> !(rd_bit && $past(rd_bit)))
        else $error("reserved status sent");
    a_quiet_writing: assert property (wr_valid |-> !rd_valid)
        else $error("reply during write phase");
    a_field_drop_ends: assert property (!field_on |=> !rd_valid)
        else $error("reply without field");
endmodule
`default_nettype wire

// *** rfid_link_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface rfid_link_if;
    logic field_on;  // reader field powers the tag
    logic wr_valid;  // one write bit this cycle
    logic wr_bit;    // write bit value
    logic wr_end;    // end of the write phase
    logic rd_valid;  // one reply bit this cycle
    logic rd_bit;    // reply bit value
    logic rd_last;   // last reply bit
    modport tag (input field_on, input wr_valid, input wr_bit, input wr_end,
        output rd_valid, output rd_bit, output rd_last);
    modport reader (output field_on, output wr_valid, output wr_bit, output wr_end,
        input rd_valid, input rd_bit, input rd_last);
endinterface
`default_nettype wire

// *** rfid_page_pkg.sv ***
`default_nettype none
package rfid_page_pkg;
    // memory geometry
    localparam int NUM_PAGES = 17;         // lockable pages
    localparam int PAGE_BITS = 80;         // data bits per page
    localparam int ID_BITS = 64;           // identification part of a page
    localparam int CHK_BITS = 16;          // block_check_word part of a page
    localparam int SEL_BITS = 24;          // selective address width
    localparam int ADDR_BITS = 8;          // write and read address byte
    localparam int PRE_BITS = 16;          // zero pre-bits of a reply
    localparam int REPLY_BITS = 128;       // reply frame length
    localparam int RX_BITS = 112;          // longest write frame
    localparam int CRC_BITS = 88;          // bits covered by frame_check_word
    localparam int LEN_W = 7;              // width of frame bit counters
    localparam int PAGE_W = 6;             // width of the page field
    localparam int IDX_W = 5;              // width of a memory index
    localparam int SEL_LSB = 8;            // selective address position in a frame
    localparam int DATA_LSB_PLAIN = 8;     // data position without selective address
    localparam int DATA_LSB_SEL = 32;      // data position after selective address
    localparam int SEL_FIELD_LSB = 0;      // selective address position in page 1
    localparam logic [7:0] START_BYTE = 8'h7e;
    localparam logic [15:0] PRE_VALUE = 16'h0000;
    localparam logic [5:0] FIRST_PAGE = 6'h01;
    localparam logic [5:0] LAST_PAGE = 6'h11;
    // command field of the write address byte
    localparam logic [1:0] CMD_READ = 2'h0;
    localparam logic [1:0] CMD_PROG = 2'h1;
    localparam logic [1:0] CMD_LOCK = 2'h2;
    localparam logic [1:0] CMD_SELREAD = 2'h3;
    // status field of the reply read address
    localparam logic [1:0] ST_UNLOCKED = 2'h0;
    localparam logic [1:0] ST_PROGRAMMED = 2'h1;
    localparam logic [1:0] ST_LOCKED = 2'h2;
    // frame check word generator, bitwise and reflected
    localparam logic [15:0] CRC_INIT = 16'h0000;
    localparam logic [15:0] CRC_POLY = 16'h8408;
    // device variants
    typedef logic [1:0] variant_t;
    localparam variant_t VAR_BASIC = 2'h0;
    localparam variant_t VAR_SELECTIVE = 2'h1;
    localparam variant_t VAR_SECURE = 2'h2;
    // reader waiting times, in clock cycles
    localparam int CHARGE_CYCLES = 64;
    localparam int REPLY_TIMEOUT = 256;

    // number of write bits that a command must carry
    function automatic logic [6:0] frame_len(input logic [1:0] cmd, input logic sel);
        int n;
        n = ADDR_BITS;
        if (sel) begin
            n = n + SEL_BITS;
        end
        if (cmd == CMD_PROG) begin
            n = n + PAGE_BITS;
        end
        return 7'(n);
    endfunction

    // frame check word over read data and read address, lsb first
    function automatic logic [15:0] crc16(input logic [87:0] d);
        logic [15:0] c;
        c = CRC_INIT;
        for (int i = 0; i < CRC_BITS; i++) begin
            if (c[0] ^ d[i]) begin
                c = (c >> 1) ^ CRC_POLY;
            end else begin
                c = c >> 1;
            end
        end
        return c;
    endfunction
endpackage
`default_nettype wire

// *** rfid_reader.sv ***
`timescale 1ns/10ps
`default_nettype none
module rfid_reader #(
    parameter int CHARGE_CYCLES = rfid_page_pkg::CHARGE_CYCLES,  // charge phase length
    parameter int REPLY_TIMEOUT = rfid_page_pkg::REPLY_TIMEOUT   // wait for first reply bit
) (
    input wire logic clk,                 // system clock
    input wire logic rst,                 // asynchronous reset
    rfid_link_if.reader link,             // link to the tag
    input wire logic start,               // pulse: begin one activation
    input wire logic charge_only,         // send no write bits
    input wire logic use_sel,             // send the selective address
    input wire logic [1:0] cmd,           // command field
    input wire logic [5:0] page,          // page number
    input wire logic [23:0] sel_addr,     // selective address of the target
    input wire logic [79:0] wr_data,      // program data with block_check_word
    output logic busy,                    // activation in progress
    output logic done,                    // pulse: activation finished
    output logic reply_ok,                // reply framing and check word good
    output logic no_reply,                // tag stayed silent
    output logic [79:0] reply_data,       // page data returned
    output logic [1:0] reply_status,      // status field returned
    output logic [5:0] reply_page         // page field returned
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    typedef enum logic [2:0] {R_IDLE, R_CHARGE, R_SEND, R_END, R_WAIT, R_RECV} reader_state_e;

    reader_state_e state;        // activation phase
    logic [111:0] tx;            // write bits, lsb first
    logic [6:0] tx_left;         // write bits still to send
    logic [127:0] rx;            // reply bits, shifted in from the top
    logic [15:0] timer;          // charge and timeout counter
    logic [111:0] next_tx;       // frame built from the request

    ////////////////////////////////////////////////////////////////////////
    // request framing, command byte first, lsb first

    // unused upper bits stay zero and are never sent
    always_comb begin
        if (use_sel) begin
            next_tx = {wr_data, sel_addr, page, cmd};
        end else begin
            next_tx = {24'h000000, wr_data, page, cmd};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // activation sequence

    // charge, write, then listen; silence ends in a timeout
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= R_IDLE;
            tx <= '0;
            tx_left <= 7'h00;
            timer <= 16'h0000;
        end else begin
            case (state)
                R_IDLE: begin
                    if (start) begin
                        state <= R_CHARGE;
                        tx <= next_tx;
                        tx_left <= charge_only ? 7'h00 : rfid_page_pkg::frame_len(cmd, use_sel);
                        timer <= 16'(CHARGE_CYCLES);
                    end
                end
                R_CHARGE: begin
                    timer <= timer - 16'h0001;
                    if (timer == 16'h0001) begin
                        state <= (tx_left == 7'h00) ? R_END : R_SEND;
                    end
                end
                R_SEND: begin
                    tx <= tx >> 1;
                    tx_left <= tx_left - 7'h01;
                    if (tx_left == 7'h01) begin
                        state <= R_END;
                    end
                end
                R_END: begin
                    state <= R_WAIT;
                    timer <= 16'(REPLY_TIMEOUT);
                end
                R_WAIT: begin
                    timer <= timer - 16'h0001;
                    if (link.rd_valid) begin
                        state <= R_RECV;
                    end else if (timer == 16'h0001) begin
                        state <= R_IDLE;
                    end
                end
                R_RECV: begin
                    if (link.rd_valid && link.rd_last) begin
                        state <= R_IDLE;
                    end
                end
                default: begin
                    state <= R_IDLE;
                end
            endcase
        end
    end

    // link drive; the field stays on through the whole activation
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            link.field_on <= 1'b0;
            link.wr_valid <= 1'b0;
            link.wr_bit <= 1'b0;
            link.wr_end <= 1'b0;
        end else begin
            // a reply bit arriving on the last timeout cycle still keeps the field up
            link.field_on <= (state != R_IDLE) &&
                !(state == R_WAIT && !link.rd_valid && timer == 16'h0001) &&
                !(state == R_RECV && link.rd_valid && link.rd_last);
            link.wr_valid <= (state == R_SEND);
            link.wr_bit <= (state == R_SEND) && tx[0];
            link.wr_end <= (state == R_END);
        end
    end

    // reply capture; the first bit ends up in the lowest position
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx <= '0;
        end else if (state == R_END) begin
            rx <= '0;
        end else if (link.rd_valid && (state == R_WAIT || state == R_RECV)) begin
            rx <= {link.rd_bit, rx[127:1]};
        end
    end

    // results, loaded once the frame or the timeout ends
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            done <= 1'b0;
            reply_ok <= 1'b0;
            no_reply <= 1'b0;
            reply_data <= '0;
            reply_status <= 2'h0;
            reply_page <= 6'h00;
        end else begin
            busy <= (state != R_IDLE) || start;
            done <= ((state == R_WAIT) && !link.rd_valid && (timer == 16'h0001)) ||
                ((state == R_RECV) && link.rd_valid && link.rd_last);
            if (state == R_WAIT && !link.rd_valid && timer == 16'h0001) begin
                no_reply <= 1'b1;
                reply_ok <= 1'b0;
            end else if (state == R_RECV && link.rd_valid && link.rd_last) begin
                no_reply <= 1'b0;
                // last bit is still on the wire, so every field sits one place up in rx
                reply_ok <= (rx[16:1] == rfid_page_pkg::PRE_VALUE) &&
                    (rx[24:17] == rfid_page_pkg::START_BYTE) &&
                    (rfid_page_pkg::crc16(rx[112:25]) == {link.rd_bit, rx[127:113]});
                reply_data <= rx[104:25];
                reply_status <= rx[106:105];
                reply_page <= rx[112:107];
            end
        end
    end

endmodule
`default_nettype wire

// *** rfid_tag.sv ***
// Function
// - seventeen pages, eighty bits plus lock each
// - sixty-four identification bits, sixteen check bits
// - lock bit set only by lock command
// - lock bit cleared only by reset
// - locked page readable, not reprogrammable
// - page 1 low 24 bits: selective address
// - selective commands need full address match
// - basic variant: no page address returns page 1
// - general read returns addressed page
// - reader sends selective address for selective read
// - program writes data, replies new contents
// - lock reply carries contents and locked status
// - selective program only after address match
// - selective lock only after address match
// - variant decides the supported commands
// - write byte: command first, lsb first
// - reply: pre-bits, start, data, address, check
// - read address: status first, then page
// - wrong write bit count: discharge silently
`timescale 1ns/10ps
`default_nettype none
module rfid_tag #(
    parameter rfid_page_pkg::variant_t VARIANT = rfid_page_pkg::VAR_BASIC
) (
    input wire logic clk,              // system clock
    input wire logic rst,              // asynchronous reset, clears memory
    rfid_link_if.tag link,             // link to the reader
    output logic [16:0] locked_pages,  // lock bit of each page
    output logic executed              // pulse when a command is executed
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    typedef enum logic [1:0] {S_LISTEN, S_EXEC, S_REPLY, S_DEAD} tag_state_e;

    tag_state_e state;                           // activation phase
    logic [79:0] mem [0:16];                     // page data
    logic [111:0] rx;                            // received write bits
    logic [6:0] rx_cnt;                          // received bit count
    logic rx_over;                               // frame longer than any command
    logic [127:0] tx;                            // reply shift register
    logic [6:0] tx_cnt;                          // reply bits left minus one
    logic [1:0] cmd;                             // command field
    logic [5:0] page;                            // page field
    logic [4:0] idx;                             // memory index of the page
    logic charge_only;                           // no write bits received
    logic need_sel;                              // selective address expected
    logic cmd_ok;                                // command supported by the variant
    logic page_ok;                               // page number in range
    logic sel_match;                             // selective address equal
    logic accept;                                // command executes
    logic do_prog;                               // memory write happens
    logic [79:0] new_data;                       // data carried by program
    logic [79:0] reply_data;                     // page data in the reply
    logic [1:0] reply_status;                    // status field in the reply
    logic [7:0] reply_addr;                      // read address byte

    ////////////////////////////////////////////////////////////////////////
    // decode of the received frame

    // command byte arrives command first, lsb first, so it sits in the low bits
    always_comb begin
        cmd = rx[1:0];
        page = rx[7:2];
        charge_only = (rx_cnt == 7'h00);
        // basic parts never carry a selective address
        need_sel = (VARIANT != rfid_page_pkg::VAR_BASIC) && (cmd != rfid_page_pkg::CMD_READ);
        page_ok = (page >= rfid_page_pkg::FIRST_PAGE) && (page <= rfid_page_pkg::LAST_PAGE);
        idx = charge_only ? 5'h00 : 5'(page - rfid_page_pkg::FIRST_PAGE);
        // bit-by-bit compare against the field held in page 1
        sel_match = (rx[rfid_page_pkg::SEL_LSB +: rfid_page_pkg::SEL_BITS] ==
            mem[0][rfid_page_pkg::SEL_FIELD_LSB +: rfid_page_pkg::SEL_BITS]);
        if (need_sel) begin
            new_data = rx[rfid_page_pkg::DATA_LSB_SEL +: rfid_page_pkg::PAGE_BITS];
        end else begin
            new_data = rx[rfid_page_pkg::DATA_LSB_PLAIN +: rfid_page_pkg::PAGE_BITS];
        end
    end

    // supported command set per variant
    always_comb begin
        cmd_ok = 1'b0;
        case (VARIANT)
            rfid_page_pkg::VAR_BASIC: begin
                // basic part has no selective read
                cmd_ok = charge_only || (cmd != rfid_page_pkg::CMD_SELREAD);
            end
            rfid_page_pkg::VAR_SELECTIVE: begin
                cmd_ok = !charge_only;
            end
            rfid_page_pkg::VAR_SECURE: begin
                // secure part refuses the unaddressed general read
                cmd_ok = !charge_only && (cmd != rfid_page_pkg::CMD_READ);
            end
            default: begin
                cmd_ok = 1'b0;
            end
        endcase
    end

    // execution decision and reply contents
    always_comb begin
        if (charge_only) begin
            accept = cmd_ok;
        end else begin
            accept = cmd_ok && page_ok && !rx_over &&
                (rx_cnt == rfid_page_pkg::frame_len(cmd, need_sel)) &&
                (!need_sel || sel_match);
        end
        // a locked page refuses the write
        do_prog = !charge_only && (cmd == rfid_page_pkg::CMD_PROG) &&
            !locked_pages[idx];
        if (do_prog) begin
            reply_data = new_data;
            reply_status = rfid_page_pkg::ST_PROGRAMMED;
        end else if (!charge_only && (cmd == rfid_page_pkg::CMD_LOCK)) begin
            reply_data = mem[idx];
            reply_status = rfid_page_pkg::ST_LOCKED;
        end else begin
            reply_data = mem[idx];
            reply_status = locked_pages[idx] ? rfid_page_pkg::ST_LOCKED :
                rfid_page_pkg::ST_UNLOCKED;
        end
        // status goes first on the air, so it takes the low bits
        reply_addr = {(charge_only ? rfid_page_pkg::FIRST_PAGE : page), reply_status};
    end

    ////////////////////////////////////////////////////////////////////////
    // activation sequence

    // a field drop ends any activation and recharges the tag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= S_LISTEN;
        end else if (!link.field_on) begin
            state <= S_LISTEN;
        end else begin
            case (state)
                S_LISTEN: begin
                    if (link.wr_end) begin
                        state <= S_EXEC;
                    end
                end
                S_EXEC: begin
                    // a refused command discharges with no reply
                    state <= accept ? S_REPLY : S_DEAD;
                end
                S_REPLY: begin
                    if (tx_cnt == 7'h00) begin
                        state <= S_DEAD;
                    end
                end
                S_DEAD: begin
                    state <= S_DEAD;
                end
                default: begin
                    state <= S_LISTEN;
                end
            endcase
        end
    end

    // write bit capture, lsb first at rising bit positions
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx <= '0;
            rx_cnt <= 7'h00;
            rx_over <= 1'b0;
        end else if (!link.field_on || (state != S_LISTEN && state != S_EXEC)) begin
            rx <= '0;
            rx_cnt <= 7'h00;
            rx_over <= 1'b0;
        end else if (state == S_LISTEN && link.wr_valid && !link.wr_end) begin
            if (rx_cnt < 7'(rfid_page_pkg::RX_BITS)) begin
                rx[rx_cnt] <= link.wr_bit;
                rx_cnt <= rx_cnt + 7'h01;
            end else begin
                // counter saturates; an overlong frame is only flagged
                rx_over <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // page memory and lock bits

    // reset stands for a blank part; the field alone never clears memory
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < rfid_page_pkg::NUM_PAGES; i++) begin
                mem[i] <= '0;
            end
        end else if (link.field_on && state == S_EXEC && accept && do_prog) begin
            // identification and block_check_word are stored as sent
            mem[idx] <= new_data;
        end
    end

    // no command clears a lock bit once set; only reset does
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            locked_pages <= '0;
        end else if (link.field_on && state == S_EXEC && accept && !charge_only &&
            cmd == rfid_page_pkg::CMD_LOCK) begin
            locked_pages[idx] <= 1'b1;
        end
    end

    // one-cycle note that a command ran
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            executed <= 1'b0;
        end else begin
            executed <= link.field_on && (state == S_EXEC) && accept;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reply transmitter

    // frame is loaded whole and shifted out lsb first, one bit a cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx <= '0;
            tx_cnt <= 7'h00;
        end else if (link.field_on && state == S_EXEC && accept) begin
            tx <= {rfid_page_pkg::crc16({reply_addr, reply_data}), reply_addr, reply_data,
                rfid_page_pkg::START_BYTE, rfid_page_pkg::PRE_VALUE};
            tx_cnt <= 7'(rfid_page_pkg::REPLY_BITS - 1);
        end else if (state == S_REPLY) begin
            tx <= tx >> 1;
            tx_cnt <= tx_cnt - 7'h01;
        end
    end

    // link outputs registered so they lag the shift register by one cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            link.rd_valid <= 1'b0;
            link.rd_bit <= 1'b0;
            link.rd_last <= 1'b0;
        end else begin
            link.rd_valid <= link.field_on && (state == S_REPLY);
            link.rd_bit <= link.field_on && (state == S_REPLY) && tx[0];
            link.rd_last <= link.field_on && (state == S_REPLY) && (tx_cnt == 7'h00);
        end
    end

endmodule
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk = 1'b0;  // 25 MHz
    logic rst = 1'b1;  // held five cycles
    logic start = 1'b0, charge_only = 1'b0, use_sel = 1'b0, busy, done, reply_ok, no_reply;
    logic executed;  // tag execute pulse
    logic [1:0] cmd = 2'h0, reply_status;
    logic [5:0] page = 6'h00, reply_page;
    logic [79:0] wr_data = 80'h0, reply_data;
    logic [16:0] locked;
    int err_count = 0, checks = 0, exec_count = 0;
    // alternating patterns catch stuck and swapped bits
    localparam logic [79:0] pat_a = 80'h1234_5678_9abc_def0_a5c3;
    localparam logic [79:0] pat_b = 80'hffff_0000_ffff_0000_0f0f;
    rfid_link_if link ();
    rfid_tag u_rfid_tag (.clk(clk), .rst(rst), .link(link), .locked_pages(locked),
        .executed(executed));
    // short charge keeps the run brief
    rfid_reader #(.CHARGE_CYCLES(4)) u_rfid_reader (.clk(clk), .rst(rst), .link(link),
        .start(start), .charge_only(charge_only), .use_sel(use_sel), .cmd(cmd), .page(page),
        .sel_addr(24'h000000), .wr_data(wr_data), .busy(busy), .done(done),
        .reply_ok(reply_ok), .no_reply(no_reply), .reply_data(reply_data),
        .reply_status(reply_status), .reply_page(reply_page));
    rfid_link_assertions u_chk (.clk(clk), .rst(rst), .field_on(link.field_on),
        .wr_valid(link.wr_valid), .wr_bit(link.wr_bit), .wr_end(link.wr_end),
        .rd_valid(link.rd_valid), .rd_bit(link.rd_bit), .rd_last(link.rd_last));
    initial begin
        forever #20 clk = ~clk;
    end
    // counts executed commands, so a refused one shows up as a missing pulse
    always @(posedge clk) begin
        if (executed === 1'b1) exec_count <= exec_count + 1;
    end
    ////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk_d(input logic [79:0] got, input logic [79:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_f(input logic [7:0] got, input logic [7:0] exp);
        chk_d({72'h0, got}, {72'h0, exp});
    endtask
    // one activation; the wait is bounded, a hang ends the run
    task automatic act(input logic co, input logic [1:0] cm, input logic [5:0] pg,
        input logic [79:0] d, input logic [79:0] ex, input logic [1:0] st, input logic nr);
        int n, e;
        n = 0;
        e = exec_count;
        @(posedge clk);
        charge_only <= co; cmd <= cm; page <= pg; wr_data <= d; start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        #1 chk_f({7'h0, busy}, 8'h01);
        do begin
            @(posedge clk);
            #1 n++;
        end while (done !== 1'b1 && n < 2000);
        if (n >= 2000) begin
            err_count++;
            summarize();
        end
        chk_f({6'h0, no_reply, reply_ok}, {6'h0, nr, !nr});
        chk_f(8'(exec_count - e), {7'h0, !nr});
        if (!nr) begin
            chk_d(reply_data, ex);
            chk_f({reply_status, reply_page}, {st, pg});
        end
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        act(1'b1, 2'h0, 6'h01, 80'h0, 80'h0, 2'h0, 1'b0);
        act(1'b0, 2'h1, 6'h11, pat_a, pat_a, 2'h1, 1'b0);
        act(1'b0, 2'h0, 6'h11, pat_b, pat_a, 2'h0, 1'b0);
        chk_d({63'h0, locked}, 80'h0);
        act(1'b0, 2'h2, 6'h11, pat_b, pat_a, 2'h2, 1'b0);
        chk_d({63'h0, locked}, {63'h0, 17'h10000});
        act(1'b0, 2'h1, 6'h11, pat_b, pat_a, 2'h2, 1'b0);
        act(1'b0, 2'h0, 6'h11, pat_b, pat_a, 2'h2, 1'b0);
        act(1'b0, 2'h3, 6'h02, pat_b, pat_a, 2'h0, 1'b1);
        act(1'b0, 2'h0, 6'h12, pat_b, pat_a, 2'h0, 1'b1);
        // a read padded with an address the basic part never expects is the wrong length
        @(posedge clk);
        use_sel <= 1'b1;
        act(1'b0, 2'h0, 6'h02, pat_b, pat_a, 2'h0, 1'b1);
        @(posedge clk);
        use_sel <= 1'b0;
        act(1'b0, 2'h0, 6'h02, pat_b, 80'h0, 2'h0, 1'b0);
        chk_d({63'h0, locked}, {63'h0, 17'h10000});
        summarize();
    end
endmodule
`default_nettype wire
